/* File: iad_ctrl.v */
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "iad_defs.vh"
module iad_ctrl (
  input wire i_core_clk,
  input wire i_rst,
  // avalon-mm slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // measurement core
  input wire [15:0] i_resistance,
  input wire [15:0] i_threshold,
  input wire i_delay_active,
  input wire [7:0] i_delay_progress,
  input wire i_selftest_run,
  input wire i_first_meas,
  input wire i_cap_over,
  input wire i_overvolt,
  input wire i_inj_lost,
  input wire i_inoperative,
  input wire i_preventive,
  input wire i_hv_sense_terminal_a,
  input wire i_hv_sense_terminal_b,
  // push buttons (asynchronous, pulse on press)
  input wire i_btn_up,
  input wire i_btn_down,
  input wire i_btn_left,
  input wire i_btn_ok,
  input wire i_btn_esc,
  input wire i_btn_ack,
  // presentation and outputs
  output reg [3:0] o_screen,
  output reg [2:0] o_status_bar,
  output reg [7:0] o_bar_progress,
  output reg o_refresh_bar_en,
  output reg o_backlight_on,
  output reg o_led_red,
  output reg o_alarm_relay,
  output reg o_prev_relay,
  output reg o_monitor_en,
  output reg o_disconnect,
  output reg [15:0] o_ack_stamp
);
  // state machine for alarm presentation
  localparam [3:0] AL_IDLE = 4'b0001;
  localparam [3:0] AL_FAULT = 4'b0010;
  localparam [3:0] AL_ACKED = 4'b0100;
  localparam [3:0] AL_TRANS = 4'b1000;

  reg [3:0] ctrl;
  reg [3:0] al_state;
  reg [3:0] next_al_state;
  reg [15:0] time_cnt;
  reg [16:0] ms_div;
  reg ovv_latched;
  reg [26:0] flash_cnt;
  reg flash_phase;
  reg [5:0] btn_s1;
  reg [5:0] btn_s2;
  reg [5:0] btn_s3;
  reg [1:0] hv_s1;
  reg [1:0] hv_s2;
  reg [3:0] edit_kind_sel;
  reg edit_start;
  reg [15:0] edit_init;
  reg [7:0] list_max;
  reg store_done;
  reg store_ok;
  wire [5:0] btn_press;
  wire edit_active;
  wire edit_busy;
  wire [1:0] edit_digit;
  wire [15:0] edit_value;
  wire [1:0] edit_msg;
  wire edit_commit;
  wire edit_kind;
  wire special;
  wire hv_open;
  wire below;
  wire edit_btn_ok;

  // parameter ids 0..3 are date, time, password, modbus address
  function kind_of;
    input [3:0] id;
    begin
      kind_of = (id <= 4'h3) ? `IAD_EKIND_NUM : `IAD_EKIND_LIST;
    end
  endfunction

  // pins pass two flops before use; third stage only for edge detect
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      btn_s1 <= 6'h00;
      btn_s2 <= 6'h00;
      btn_s3 <= 6'h00;
      hv_s1 <= 2'h0;
      hv_s2 <= 2'h0;
    end else begin
      btn_s1 <= {i_btn_ack, i_btn_esc, i_btn_ok, i_btn_left, i_btn_down, i_btn_up};
      btn_s2 <= btn_s1;
      btn_s3 <= btn_s2;
      // strapping may change under power, so the terminals are synchronised too
      hv_s1 <= {i_hv_sense_terminal_b, i_hv_sense_terminal_a};
      hv_s2 <= hv_s1;
    end
  end
  assign btn_press = btn_s2 & ~btn_s3;

  assign edit_kind = kind_of(edit_kind_sel);
  // shorted terminals read as equal levels
  assign hv_open = (hv_s2[0] != hv_s2[1]) && ctrl[`IAD_CTRL_ADAPT_PN];
  // any of these forces red led and alarm relay; the screen chain picks one
  assign special = i_cap_over | ovv_latched | i_inj_lost | i_inoperative | hv_open;
  // strict compare: a reading equal to the threshold is no fault
  assign below = i_resistance < i_threshold;
  // ok while not editing clears a transient alarm (AL_TRANS) instead
  assign edit_btn_ok = btn_press[3] & edit_active;

  // the core times the alarm delay; entry only waits for it to end
  always @* begin
    next_al_state = al_state;
    case (al_state)
      AL_IDLE:
        if (below && !i_delay_active)
          next_al_state = AL_FAULT;
      AL_FAULT:
        if (btn_press[5])
          next_al_state = AL_ACKED;
        else if (!below)
          next_al_state = AL_TRANS;
      AL_ACKED:
        if (!below)
          next_al_state = AL_IDLE;
      AL_TRANS:
        if (btn_press[5] || (btn_press[3] && !edit_active))
          next_al_state = below ? AL_FAULT : AL_IDLE;
        else if (below)
          next_al_state = AL_FAULT;
      default: next_al_state = AL_IDLE;
    endcase
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      al_state <= AL_IDLE;
      ovv_latched <= 1'b0;
      time_cnt <= 16'h0000;
      ms_div <= 17'h00000;
      flash_cnt <= 27'h0000000;
      flash_phase <= 1'b0;
      o_ack_stamp <= 16'h0000;
    end else begin
      al_state <= next_al_state;
      // coarse time stamp in milliseconds
      // one millisecond of cycles needs 17 bits
      if (ms_div == `IAD_MS_LAST) begin
        ms_div <= 17'h00000;
        time_cnt <= time_cnt + 16'h0001;
      end else begin
        ms_div <= ms_div + 17'h00001;
      end
      if (al_state == AL_FAULT && next_al_state == AL_ACKED)
        o_ack_stamp <= time_cnt;
      // only a reset (aux supply cycle) releases this
      if (i_overvolt)
        ovv_latched <= 1'b1;
      // free running: the first phase of an alarm may be short
      if (flash_cnt == `IAD_FLASH_LAST) begin
        flash_cnt <= 27'h0000000;
        flash_phase <= ~flash_phase;
      end else begin
        flash_cnt <= flash_cnt + 27'h0000001;
      end
    end
  end

  // presentation outputs
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_screen <= `IAD_SCR_RES;
      o_status_bar <= `IAD_BAR_NONE;
      o_bar_progress <= 8'h00;
      o_refresh_bar_en <= 1'b0;
      o_backlight_on <= 1'b1;
      o_led_red <= 1'b0;
      o_alarm_relay <= 1'b0;
      o_prev_relay <= 1'b0;
      o_monitor_en <= 1'b0;
      o_disconnect <= 1'b0;
    end else begin
      o_refresh_bar_en <= ~ctrl[`IAD_CTRL_FILT_SHORT];
      o_bar_progress <= i_delay_progress;
      // overvoltage outranks all: it also keeps the line disconnected
      if (ovv_latched)
        o_screen <= `IAD_SCR_OVV;
      else if (i_inoperative)
        o_screen <= `IAD_SCR_INOP;
      else if (i_cap_over)
        o_screen <= `IAD_SCR_CAP;
      else if (i_inj_lost)
        o_screen <= ctrl[`IAD_CTRL_INJ_LOSS_ALM] ? `IAD_SCR_INJ : `IAD_SCR_RES_HIGH;
      else if (hv_open)
        o_screen <= `IAD_SCR_HVOPEN;
      else if (al_state == AL_FAULT)
        o_screen <= `IAD_SCR_FAULT;
      else if (al_state == AL_ACKED)
        o_screen <= `IAD_SCR_ACKED;
      else if (al_state == AL_TRANS)
        o_screen <= `IAD_SCR_TRANS;
      else
        o_screen <= `IAD_SCR_RES;
      if (i_selftest_run)
        o_status_bar <= `IAD_BAR_SELFTEST;
      else if (i_first_meas)
        o_status_bar <= `IAD_BAR_FIRSTMEAS;
      else if (i_delay_active && below)
        o_status_bar <= `IAD_BAR_DELAY;
      else if (al_state == AL_ACKED)
        o_status_bar <= `IAD_BAR_ACK;
      else if (al_state == AL_FAULT)
        o_status_bar <= `IAD_BAR_PICKUP;
      else if (al_state == AL_TRANS)
        o_status_bar <= `IAD_BAR_DROPOUT;
      else
        o_status_bar <= `IAD_BAR_NONE;
      // flashing only while alarm signalled, not once acknowledged
      o_backlight_on <= (al_state == AL_FAULT) ? flash_phase : 1'b1;
      o_led_red <= special;
      o_alarm_relay <= special | (al_state == AL_FAULT) | (al_state == AL_ACKED);
      if (ctrl[`IAD_CTRL_PREV_MIRROR])
        o_prev_relay <= special | (al_state == AL_FAULT) | (al_state == AL_ACKED);
      else
        o_prev_relay <= i_preventive;
      o_monitor_en <= ~(ovv_latched | i_cap_over | i_inj_lost | i_inoperative);
      o_disconnect <= ovv_latched;
    end
  end

  // avalon slave: one wait cycle per access, so readdata lines up with waitrequest low
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
      ctrl <= `IAD_CTRL_RST;
      edit_kind_sel <= 4'h0;
      edit_start <= 1'b0;
      edit_init <= 16'h0000;
      list_max <= 8'h00;
      store_done <= 1'b0;
      store_ok <= 1'b0;
    end else begin
      edit_start <= 1'b0;
      store_done <= 1'b0;
      if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b0;
        o_avs_readdata <= 32'h00000000;
        if (i_avs_read) begin
          case (i_avs_address)
            `IAD_REG_CTRL: o_avs_readdata <= {28'h0000000, ctrl};
            `IAD_REG_STATUS: o_avs_readdata <= {20'h00000, o_ack_stamp[7:0], al_state};
            `IAD_REG_SCREEN: o_avs_readdata <= {22'h000000, o_status_bar, ovv_latched,
                                               hv_open, special, o_screen};
            `IAD_REG_EDIT: o_avs_readdata <= {16'h0000, 4'h0, edit_msg, edit_digit,
                                             edit_commit, edit_busy, edit_active, edit_kind,
                                             edit_kind_sel};
            `IAD_REG_VALUE: o_avs_readdata <= {16'h0000, edit_value};
            `IAD_REG_LIST: o_avs_readdata <= {24'h000000, list_max};
            default: o_avs_readdata <= 32'h00000000;
          endcase
        end
      end else begin
        o_avs_waitrequest <= 1'b1;
        // a write lands only at the edge where the master sees waitrequest low
        if (i_avs_write && !o_avs_waitrequest) begin
          case (i_avs_address)
            `IAD_REG_CTRL: ctrl <= i_avs_writedata[3:0];
            `IAD_REG_EDIT: begin
              edit_kind_sel <= i_avs_writedata[3:0];
              edit_init <= i_avs_writedata[31:16];
              edit_start <= i_avs_writedata[4];
            end
            `IAD_REG_LIST: list_max <= i_avs_writedata[7:0];
            `IAD_REG_COMMIT: begin
              store_done <= 1'b1;
              store_ok <= i_avs_writedata[0]; // software validates value
            end
            default: ;
          endcase
        end
      end
    end
  end

  iad_edit u_edit (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(edit_start),
    .i_kind(edit_kind),
    .i_init_value(edit_init),
    .i_list_max(list_max),
    .i_btn_up(btn_press[0]),
    .i_btn_down(btn_press[1]),
    .i_btn_left(btn_press[2]),
    .i_btn_ok(edit_btn_ok),
    .i_btn_esc(btn_press[4]),
    .i_store_done(store_done),
    .i_store_ok(store_ok),
    .o_active(edit_active),
    .o_busy(edit_busy),
    .o_digit(edit_digit),
    .o_value(edit_value),
    .o_msg(edit_msg),
    .o_commit(edit_commit)
  );
endmodule

/* File: iad_ctrl_props.sv */
`timescale 1ns/1ps
`include "iad_defs.vh"
module iad_ctrl_chk (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // bus
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  // measurement core
  input wire logic [15:0] i_resistance,
  input wire logic [15:0] i_threshold,
  input wire logic i_delay_active,
  input wire logic [7:0] i_delay_progress,
  input wire logic i_cap_over,
  input wire logic i_overvolt,
  input wire logic i_inj_lost,
  input wire logic i_inoperative,
  // presentation
  input wire logic [3:0] o_screen,
  input wire logic [7:0] o_bar_progress,
  input wire logic o_backlight_on,
  input wire logic o_led_red,
  input wire logic o_alarm_relay,
  input wire logic o_monitor_en,
  input wire logic o_disconnect
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wait_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus request not answered");
  wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  fault_entry_a: assert property (
    o_screen == `IAD_SCR_RES && i_resistance < i_threshold && !i_delay_active
    && !(i_cap_over || i_overvolt || i_inj_lost || i_inoperative)
    |-> ##[1:3] o_screen == `IAD_SCR_FAULT) else $error("fault screen missing");
  led_special_a: assert property (
    o_screen inside {`IAD_SCR_CAP, `IAD_SCR_OVV, `IAD_SCR_INJ, `IAD_SCR_HVOPEN, `IAD_SCR_INOP}
    |-> o_led_red && o_alarm_relay) else $error("special state without red led and relay");
  ovv_state_a: assert property (o_screen == `IAD_SCR_OVV |-> o_disconnect && !o_monitor_en)
    else $error("overvoltage still connected");
  ovv_latch_a: assert property (o_disconnect |=> o_disconnect)
    else $error("disconnect released without reset");
  no_monitor_a: assert property (
    o_screen == `IAD_SCR_CAP || o_screen == `IAD_SCR_INJ |-> !o_monitor_en)
    else $error("monitoring not suspended");
  no_flash_a: assert property ((o_screen != `IAD_SCR_FAULT) [*2] |-> o_backlight_on)
    else $error("backlight off outside alarm");
  bar_follow_a: assert property (!i_rst |=> o_bar_progress == $past(i_delay_progress))
    else $error("delay progress not passed on");
  fault_c: cover property (o_screen == `IAD_SCR_FAULT);
  acked_c: cover property (o_screen == `IAD_SCR_ACKED);
  ovv_c: cover property (o_screen == `IAD_SCR_OVV);
endmodule

/* File: iad_defs.vh */
`ifndef IAD_DEFS_VH
`define IAD_DEFS_VH
// register word addresses (avalon word index)
`define IAD_REG_CTRL 4'h0
`define IAD_REG_STATUS 4'h1
`define IAD_REG_SCREEN 4'h2
`define IAD_REG_EDIT 4'h3
`define IAD_REG_VALUE 4'h4
`define IAD_REG_LIST 4'h5
`define IAD_REG_COMMIT 4'h6
// ctrl fields
`define IAD_CTRL_FILT_SHORT 0
`define IAD_CTRL_INJ_LOSS_ALM 1
`define IAD_CTRL_ADAPT_PN 2
`define IAD_CTRL_PREV_MIRROR 3
`define IAD_CTRL_RST 4'h0
// screen codes
`define IAD_SCR_RES 4'h0
`define IAD_SCR_FAULT 4'h1
`define IAD_SCR_ACKED 4'h2
`define IAD_SCR_TRANS 4'h3
`define IAD_SCR_CAP 4'h4
`define IAD_SCR_OVV 4'h5
`define IAD_SCR_INJ 4'h6
`define IAD_SCR_HVOPEN 4'h7
`define IAD_SCR_INOP 4'h8
`define IAD_SCR_RES_HIGH 4'h9
// status bar codes
`define IAD_BAR_NONE 3'h0
`define IAD_BAR_DELAY 3'h1
`define IAD_BAR_PICKUP 3'h2
`define IAD_BAR_DROPOUT 3'h3
`define IAD_BAR_ACK 3'h4
`define IAD_BAR_SELFTEST 3'h5
`define IAD_BAR_FIRSTMEAS 3'h6
// edit modes and results
`define IAD_EKIND_LIST 1'b0
`define IAD_EKIND_NUM 1'b1
`define IAD_NDIGITS 4
`define IAD_MSG_NONE 2'h0
`define IAD_MSG_SAVED 2'h1
`define IAD_MSG_ERROR 2'h2
// timing
`define IAD_FLASH_MS 500
`define IAD_SAVED_MS 1000
`define IAD_CLK_KHZ 125000
`define IAD_FLASH_CYC (`IAD_FLASH_MS * `IAD_CLK_KHZ)
`define IAD_SAVED_CYC (`IAD_SAVED_MS * `IAD_CLK_KHZ)
// last count of a flash phase and of a millisecond, sized to their counters
`define IAD_FLASH_LAST 27'h3B9AC9F
`define IAD_MS_LAST 17'h1E847
`endif

/* File: iad_edit.v */
`timescale 1ns/1ps
`include "iad_defs.vh"
module iad_edit #(
  parameter SAVED_CYC = `IAD_SAVED_CYC
) (
  input wire i_core_clk,
  input wire i_rst,
  // start and buttons, one-cycle pulses; kind, initial value and list bound held
  input wire i_start,
  input wire i_kind,
  input wire [15:0] i_init_value,
  input wire [7:0] i_list_max,
  input wire i_btn_up,
  input wire i_btn_down,
  input wire i_btn_left,
  input wire i_btn_ok,
  input wire i_btn_esc,
  // store answer
  input wire i_store_done,
  input wire i_store_ok,
  // state
  output reg o_active,
  output reg o_busy,
  output reg [1:0] o_digit,
  output reg [15:0] o_value,
  output reg [1:0] o_msg,
  output reg o_commit
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EDIT = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;
  reg [2:0] state;
  reg [27:0] msg_cnt;

  // bcd nibble increment with wrap 9 to 0
  function [3:0] bcd_inc;
    input [3:0] d;
    begin
      bcd_inc = (d >= 4'h9) ? 4'h0 : d + 4'h1;
    end
  endfunction

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      o_active <= 1'b0;
      o_busy <= 1'b0;
      o_digit <= 2'h0;
      o_value <= 16'h0000;
      o_msg <= `IAD_MSG_NONE;
      o_commit <= 1'b0;
      msg_cnt <= 28'h0000000;
    end else begin
      o_commit <= 1'b0;
      if (msg_cnt != 28'h0000000) begin
        msg_cnt <= msg_cnt - 28'h0000001;
        if (msg_cnt == 28'h0000001)
          o_msg <= `IAD_MSG_NONE;
      end
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            state <= ST_EDIT;
            o_active <= 1'b1;
            o_value <= i_init_value;
            o_digit <= 2'h0;
            o_msg <= `IAD_MSG_NONE;
          end
        end
        ST_EDIT: begin
          if (i_btn_esc) begin
            state <= ST_IDLE;
            o_active <= 1'b0;
          end else if (i_btn_ok) begin
            state <= ST_WAIT;
            o_busy <= 1'b1;
            o_commit <= 1'b1;
          end else if (i_kind == `IAD_EKIND_NUM) begin
            if (i_btn_up)
              o_value[o_digit*4 +: 4] <= bcd_inc(o_value[o_digit*4 +: 4]);
            else if (i_btn_left)
              o_digit <= o_digit + 2'h1; // wraps leftmost to rightmost
          end else begin
            if (i_btn_up)
              o_value <= (o_value[7:0] >= i_list_max) ? 16'h0000 : o_value + 16'h0001;
            else if (i_btn_down)
              o_value <= (o_value == 16'h0000) ? {8'h00, i_list_max} : o_value - 16'h0001;
          end
        end
        ST_WAIT: begin
          if (i_store_done) begin
            o_busy <= 1'b0;
            msg_cnt <= SAVED_CYC[27:0];
            if (i_store_ok) begin
              o_msg <= `IAD_MSG_SAVED;
              o_active <= 1'b0;
              state <= ST_IDLE;
            end else begin
              o_msg <= `IAD_MSG_ERROR; // stays editing
              state <= ST_EDIT;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: iad_far_model.sv */
`timescale 1ns/1ps
module iad_far_model (
  // clock
  input wire logic i_core_clk,
  // measurement core
  output logic [15:0] o_resistance,
  output logic [15:0] o_threshold,
  output logic o_delay_active,
  output logic [7:0] o_delay_progress,
  output logic o_selftest_run,
  output logic o_first_meas,
  output logic o_cap_over,
  output logic o_overvolt,
  output logic o_inj_lost,
  output logic o_inoperative,
  output logic o_preventive,
  output logic o_hv_a,
  output logic o_hv_b,
  // buttons
  output logic o_btn_up,
  output logic o_btn_down,
  output logic o_btn_left,
  output logic o_btn_ok,
  output logic o_btn_esc,
  output logic o_btn_ack
);
  task automatic meas(input logic [15:0] r, input logic [15:0] t);
    o_resistance <= r;
    o_threshold <= t;
  endtask
  task automatic delay(input logic on, input logic [7:0] p);
    o_delay_active <= on;
    o_delay_progress <= p;
  endtask
  // f: hv_b hv_a prev inop inj ovv cap first selftest
  task automatic status(input logic [8:0] f);
    {o_hv_b, o_hv_a, o_preventive, o_inoperative, o_inj_lost, o_overvolt} <= f[8:3];
    {o_cap_over, o_first_meas, o_selftest_run} <= f[2:0];
  endtask
  // held well past the two-flop sync, then a gap so presses never merge
  task automatic press(input int b);
    {o_btn_ack, o_btn_esc, o_btn_ok, o_btn_left, o_btn_down, o_btn_up} <= 6'h01 << b;
    repeat (4) @(posedge i_core_clk);
    {o_btn_ack, o_btn_esc, o_btn_ok, o_btn_left, o_btn_down, o_btn_up} <= 6'h00;
    repeat (8) @(posedge i_core_clk);
  endtask
  // quiet far side: no fault, reading well above threshold, no key held
  task automatic idle();
    meas(16'hFFFF, 16'h0100);
    delay(1'b0, 8'h00);
    status(9'h000);
    {o_btn_ack, o_btn_esc, o_btn_ok, o_btn_left, o_btn_down, o_btn_up} <= 6'h00;
  endtask
endmodule

/* File: tb_insulation_alarm_display_ctrl.sv */
`timescale 1ns/1ps
`include "iad_defs.vh"
module tb_insulation_alarm_display_ctrl;
  logic i_core_clk = 1'b0;
  logic i_rst;
  logic [3:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [31:0] i_avs_writedata;
  wire [31:0] o_avs_readdata;
  wire [15:0] o_ack_stamp;
  wire [15:0] i_resistance, i_threshold;
  wire [7:0] i_delay_progress, o_bar_progress;
  wire [3:0] o_screen;
  wire [2:0] o_status_bar;
  wire o_avs_waitrequest, i_delay_active, i_selftest_run, i_first_meas, i_cap_over;
  wire i_overvolt, i_inj_lost, i_inoperative, i_preventive;
  wire i_hv_sense_terminal_a, i_hv_sense_terminal_b;
  wire i_btn_up, i_btn_down, i_btn_left, i_btn_ok, i_btn_esc, i_btn_ack;
  wire o_refresh_bar_en, o_backlight_on, o_led_red, o_alarm_relay, o_prev_relay;
  wire o_monitor_en, o_disconnect;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [15:0] seed = 16'h000F;
  logic [15:0] v;
  logic [31:0] rv;
  logic [8:0] sf [3] = '{9'h004, 9'h010, 9'h020};
  logic [3:0] se [3] = '{`IAD_SCR_CAP, `IAD_SCR_INJ, `IAD_SCR_INOP};

  iad_ctrl iad_ctrl_i (.i_core_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_resistance, .i_threshold,
    .i_delay_active, .i_delay_progress, .i_selftest_run, .i_first_meas, .i_cap_over,
    .i_overvolt, .i_inj_lost, .i_inoperative, .i_preventive, .i_hv_sense_terminal_a,
    .i_hv_sense_terminal_b, .i_btn_up, .i_btn_down, .i_btn_left, .i_btn_ok, .i_btn_esc,
    .i_btn_ack, .o_screen, .o_status_bar, .o_bar_progress, .o_refresh_bar_en,
    .o_backlight_on, .o_led_red, .o_alarm_relay, .o_prev_relay, .o_monitor_en,
    .o_disconnect, .o_ack_stamp);
  iad_far_model iad_far_model_i (.i_core_clk, .o_resistance(i_resistance),
    .o_threshold(i_threshold), .o_delay_active(i_delay_active),
    .o_delay_progress(i_delay_progress), .o_selftest_run(i_selftest_run),
    .o_first_meas(i_first_meas), .o_cap_over(i_cap_over), .o_overvolt(i_overvolt),
    .o_inj_lost(i_inj_lost), .o_inoperative(i_inoperative), .o_preventive(i_preventive),
    .o_hv_a(i_hv_sense_terminal_a), .o_hv_b(i_hv_sense_terminal_b), .o_btn_up(i_btn_up),
    .o_btn_down(i_btn_down), .o_btn_left(i_btn_left), .o_btn_ok(i_btn_ok),
    .o_btn_esc(i_btn_esc), .o_btn_ack(i_btn_ack));

  initial begin
    forever #4 i_core_clk = ~i_core_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] bcd_inc(input logic [15:0] x, input int d);
    logic [3:0] n;
    n = x[d*4 +: 4];
    x[d*4 +: 4] = (n == 4'h9) ? 4'h0 : n + 4'h1;
    return x;
  endfunction

  task automatic results();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= ~w;
    @(posedge i_core_clk);
    while (o_avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 40) begin
        n_mismatch++;
        results();
      end
      @(posedge i_core_clk);
    end
    rv = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic scr(input logic [3:0] e);
    int n;
    n = 0;
    while (o_screen !== e && n < 30) begin
      n++;
      @(posedge i_core_clk);
    end
    chk(o_screen, e);
    if (o_screen !== e)
      results();
  endtask
  task automatic ed_rd();
    cyc(2);
    bus(1'b0, `IAD_REG_EDIT, 32'h0);
  endtask

  initial begin
    cyc(50000);
    n_mismatch++;
    results();
  end

  initial begin
    i_rst <= 1'b1;
    {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} <= 38'h0;
    iad_far_model_i.idle();
    cyc(10);
    i_rst <= 1'b0;
    cyc(1);
    chk(o_avs_waitrequest, 1'b1);
    scr(`IAD_SCR_RES);
    chk(o_backlight_on, 1'b1);
    bus(1'b0, 4'hF, 32'h0);
    chk(rv, 32'h0);
    bus(1'b1, `IAD_REG_CTRL, 32'h1);
    bus(1'b0, `IAD_REG_CTRL, 32'h0);
    chk(rv, 32'h1);
    chk(o_refresh_bar_en, 1'b0);
    bus(1'b1, `IAD_REG_CTRL, 32'h0);
    cyc(2);
    chk(o_refresh_bar_en, 1'b1);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      iad_far_model_i.meas(seed | 16'h1, seed >> 1);
      iad_far_model_i.delay(1'b0, seed[7:0]);
      cyc(4);
      chk(o_screen, `IAD_SCR_RES);
    end
    iad_far_model_i.status(9'h001);
    cyc(8);
    chk(o_status_bar, `IAD_BAR_SELFTEST);
    iad_far_model_i.status(9'h002);
    cyc(8);
    chk(o_status_bar, `IAD_BAR_FIRSTMEAS);
    iad_far_model_i.status(9'h000);
    iad_far_model_i.delay(1'b1, 8'h40);
    iad_far_model_i.meas(16'h0100, 16'h0200);
    cyc(8);
    chk(o_status_bar, `IAD_BAR_DELAY);
    chk(o_screen, `IAD_SCR_RES);
    iad_far_model_i.delay(1'b0, 8'h00);
    scr(`IAD_SCR_FAULT);
    chk({o_status_bar, o_backlight_on}, {`IAD_BAR_PICKUP, 1'b0});
    iad_far_model_i.press(5);
    scr(`IAD_SCR_ACKED);
    chk(o_status_bar, `IAD_BAR_ACK);
    chk(o_ack_stamp, 16'h0000);
    iad_far_model_i.meas(16'h0300, 16'h0200);
    cyc(8);
    iad_far_model_i.meas(16'h0100, 16'h0200);
    scr(`IAD_SCR_FAULT);
    iad_far_model_i.meas(16'h0300, 16'h0200);
    scr(`IAD_SCR_TRANS);
    chk(o_status_bar, `IAD_BAR_DROPOUT);
    iad_far_model_i.press(5);
    scr(`IAD_SCR_RES);
    // mirror on, injection-loss screen on
    bus(1'b1, `IAD_REG_CTRL, 32'hA);
    for (int k = 0; k < 3; k++) begin
      iad_far_model_i.status(sf[k]);
      scr(se[k]);
      cyc(2);
      chk({o_led_red, o_alarm_relay, o_prev_relay, o_monitor_en}, 4'hE);
      iad_far_model_i.status(9'h000);
      scr(`IAD_SCR_RES);
    end
    bus(1'b1, `IAD_REG_CTRL, 32'h0);
    iad_far_model_i.status(9'h050);
    scr(`IAD_SCR_RES_HIGH);
    chk(o_prev_relay, 1'b1);
    iad_far_model_i.status(9'h080);
    bus(1'b1, `IAD_REG_CTRL, 32'h4);
    scr(`IAD_SCR_HVOPEN);
    bus(1'b1, `IAD_REG_CTRL, 32'h0);
    scr(`IAD_SCR_RES);
    iad_far_model_i.status(9'h000);
    for (int id = 0; id < 8; id++) begin
      bus(1'b1, `IAD_REG_EDIT, 32'h10 + id);
      ed_rd();
      chk(rv[9:0], {2'b00, 3'b001, id < 4, id[3:0]});
      iad_far_model_i.press(4);
      ed_rd();
      chk({rv[7], rv[5]}, 2'b00);
    end
    for (int r = 0; r < 2; r++) begin
      seed = lfsr(seed);
      v = r ? 16'h9999 : {1'b0, seed[14:12], 1'b0, seed[10:8], 1'b0, seed[6:4], 1'b0, seed[2:0]};
      bus(1'b1, `IAD_REG_EDIT, {v, 16'h0012});
      iad_far_model_i.press(0);
      bus(1'b0, `IAD_REG_VALUE, 32'h0);
      v = bcd_inc(v, 0);
      chk(rv[15:0], v);
      for (int j = 1; j < 6; j++) begin
        iad_far_model_i.press(2);
        ed_rd();
        chk(rv[9:8], j % 4);
      end
      iad_far_model_i.press(0);
      bus(1'b0, `IAD_REG_VALUE, 32'h0);
      v = bcd_inc(v, 1);
      chk(rv[15:0], v);
      iad_far_model_i.press(3);
      ed_rd();
      chk(rv[6], 1'b1);
      bus(1'b1, `IAD_REG_COMMIT, 32'h0);
      ed_rd();
      chk({rv[11:10], rv[5]}, {`IAD_MSG_ERROR, 1'b1});
      iad_far_model_i.press(3);
      bus(1'b1, `IAD_REG_COMMIT, 32'h1);
      ed_rd();
      chk({rv[11:10], rv[5]}, {`IAD_MSG_SAVED, 1'b0});
    end
    bus(1'b1, `IAD_REG_LIST, 32'h3);
    bus(1'b1, `IAD_REG_EDIT, 32'h0001_0015);
    for (int j = 0; j < 3; j++) begin
      iad_far_model_i.press(j == 2);
      bus(1'b0, `IAD_REG_VALUE, 32'h0);
      chk(rv[15:0], (j == 2) ? 2 : j + 2);
    end
    iad_far_model_i.press(3);
    bus(1'b1, `IAD_REG_COMMIT, 32'h1);
    ed_rd();
    chk({rv[11:10], rv[5]}, {`IAD_MSG_SAVED, 1'b0});
    iad_far_model_i.status(9'h008);
    scr(`IAD_SCR_OVV);
    iad_far_model_i.status(9'h000);
    cyc(20);
    chk({o_screen, o_disconnect}, {`IAD_SCR_OVV, 1'b1});
    i_rst <= 1'b1;
    cyc(3);
    i_rst <= 1'b0;
    scr(`IAD_SCR_RES);
    chk(o_disconnect, 1'b0);
    results();
  end
endmodule

bind iad_ctrl iad_ctrl_chk iad_ctrl_chk_i (.i_core_clk, .i_rst, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .i_resistance, .i_threshold, .i_delay_active, .i_delay_progress,
  .i_cap_over, .i_overvolt, .i_inj_lost, .i_inoperative, .o_screen, .o_bar_progress,
  .o_backlight_on, .o_led_red, .o_alarm_relay, .o_monitor_en, .o_disconnect);
